// File: pkg/ustw_pkg.sv
/*
 * constants, register map and types of the universal serial two-wire core.
 * assumes a 50 MHz system clock and a byte-wide register port.
 */
package ustw_pkg;
   // --------------------------------------------------------------
   // timing
   // --------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned SDA_DLY_NS    = 50;
   localparam int unsigned SDA_DLY_CYC   = (SDA_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // --------------------------------------------------------------
   // widths and register addresses
   // --------------------------------------------------------------
   localparam int unsigned AW = 8;
   localparam int unsigned DW = 8;
   localparam int unsigned CW = 4;
   localparam logic [AW-1:0] ADDR_CTRL   = 8'h0c;
   localparam logic [AW-1:0] ADDR_STATUS = 8'h0d;
   localparam logic [AW-1:0] ADDR_DATA   = 8'h0e;
   localparam logic [AW-1:0] ADDR_BUF    = 8'h0f;
   localparam logic [AW-1:0] ADDR_PORT   = 8'h10;

   // --------------------------------------------------------------
   // field positions
   // --------------------------------------------------------------
   localparam int unsigned CTRL_SIE     = 7;
   localparam int unsigned CTRL_OIE     = 6;
   localparam int unsigned CTRL_WM_LO   = 4;
   localparam int unsigned CTRL_CS_LO   = 2;
   localparam int unsigned CTRL_CLK     = 1;
   localparam int unsigned CTRL_TC      = 0;
   localparam int unsigned ST_SF        = 7;
   localparam int unsigned ST_OF        = 6;
   localparam int unsigned ST_PF        = 5;
   localparam int unsigned PORT_DIR_SDA = 0;
   localparam int unsigned PORT_DIR_SCL = 1;
   localparam int unsigned PORT_OUT_SDA = 2;
   localparam int unsigned PORT_OUT_SCL = 3;
   localparam int unsigned PORT_DIR_DO  = 4;

   // --------------------------------------------------------------
   // values and types
   // --------------------------------------------------------------
   localparam logic [CW-1:0] CNT_MAX  = 4'hf;
   localparam logic [CW-1:0] CNT_ONE  = 4'h1;
   localparam logic [DW-1:0] RST_BYTE = 8'h00;
   typedef enum logic [1:0] {WM_NONE, WM_THREE, WM_TWO, WM_TWO_HOLD} ustw_mode_e;
   typedef logic [DW-1:0] ustw_byte_t;
endpackage

// File: hw/ustw_sync.sv
/*
 * two-flop synchroniser for a group of pin inputs.
 * assumes the inputs are unrelated to clock_i; only the second stage is used.
 */
`timescale 1ns/1ps
module ustw_sync #(
   parameter int unsigned W = 2
) (
   input  wire logic         clock_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } ustw_sync_s;

   ustw_sync_s st_q;
   ustw_sync_s st_d;

   // first stage feeds the second only
   always_comb begin
      st_d.s1 = d_i;
      st_d.s2 = st_q.s1;
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         st_q <= '1; // pulled-up idle level, so no false pin edge follows reset
      end else begin
         st_q <= st_d;
      end
   end

   assign q_o = st_q.s2;
endmodule

// File: hw/ustw_edge.sv
/*
 * edge finder for one synchronised level.
 * assumes lvl_i already lives in the clock_i domain.
 */
`timescale 1ns/1ps
module ustw_edge (
   input  wire logic clock_i,
   input  wire logic rst_i,
   input  wire logic lvl_i,
   output logic      rise_o,
   output logic      fall_o
);
   typedef struct packed {
      logic prev;
   } ustw_edge_s;

   ustw_edge_s st_q;
   ustw_edge_s st_d;

   // remember last level
   always_comb begin
      st_d.prev = lvl_i;
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         st_q <= '1; // idle-high lines: a low reset value would fake a rise
      end else begin
         st_q <= st_d;
      end
   end

   // one-cycle pulses against the remembered level
   assign rise_o = lvl_i & ~st_q.prev;
   assign fall_o = ~lvl_i & st_q.prev;
endmodule

// File: hw/ustw_core.sv
/*
 * universal serial two-wire core: shift data register with output latch,
 * buffer register, 4-bit edge counter, start/stop detection and scl hold.
 * assumes pins are resolved outside (open drain with pull-ups) and the
 * link clock is sampled by clock_i at well under half its rate.
 */
// Decided for this implementation: the strobed register port.
// Contract
// - only the master clocks the bus; slave alone uses scl hold.
// - every serial clock also advances the bit counter.
// - two-wire start condition sets the start flag.
// - after start, hold scl low at its fall until flag cleared.
// - sample sda into shift register on every scl rise.
// - counter overflow after eight bits holds scl low until released.
// - acknowledge drives sda low; software presets counter to fourteen.
// - direction bit one means slave drives sda for following bytes.
// - slave that cannot accept withholds acknowledge of last byte.
// - start detection only in two-wire mode, sda delayed against scl.
// - start detection works without the processor clock running; here it needs clock_i running.
// - serial clock stays below half the system clock.
// - external clock counts both rising and falling edges.
// - counter at fifteen overflows on next external edge.
// - shift left per clock; a coinciding write wins, no shift.
// - with no wire mode, data and clock inputs still work.
// - output follows msb through latch, open per clock source.
// - drive data pin only while its direction bit is one.
// - on completion copy shift data into buffer register.
// - other modes: any clock edge sets start flag, cleared by one.
// - overflow flag on fifteen to zero, cleared by one, releases hold.
// - two-wire stop condition sets stop flag, cleared by one.
// - collision bit shows msb differing from sda pin.
// - wire mode none disables outputs, hold and start detection.
`timescale 1ns/1ps
module ustw_core
   import ustw_pkg::*;
(
   input  wire logic                  clock_i,
   input  wire logic                  rst_i,
   input  wire logic [ustw_pkg::AW-1:0] addr_i,
   input  wire logic [ustw_pkg::DW-1:0] wdata_i,
   input  wire logic                  we_i,
   input  wire logic                  re_i,
   output logic      [ustw_pkg::DW-1:0] rdata_o,
   input  wire logic                  timer_match_i,
   input  wire logic                  sda_i,
   output logic                       sda_o,
   output logic                       sda_oe_o,
   input  wire logic                  scl_i,
   output logic                       scl_o,
   output logic                       scl_oe_o,
   output logic                       do_o,
   output logic                       do_oe_o,
   output logic                       start_irq_o,
   output logic                       ovf_irq_o
);
   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   typedef struct packed {
      logic                   sie;
      logic                   oie;
      ustw_mode_e             wm;
      logic [1:0]             cs;
      logic                   tcsel;
      logic                   dir_sda;
      logic                   dir_scl;
      logic                   prt_sda;
      logic                   prt_scl;
      logic                   dir_do;
      ustw_byte_t             shift;
      ustw_byte_t             buffer;
      logic [CW-1:0]          cnt;
      logic                   sf;
      logic                   of;
      logic                   pf;
      logic                   shold;
      logic                   latch;
      logic [SDA_DLY_CYC-1:0] sda_dly;
      ustw_byte_t             rdata;
      logic                   sda_o;
      logic                   sda_oe;
      logic                   scl_o;
      logic                   scl_oe;
      logic                   do_o;
      logic                   do_oe;
      logic                   sirq;
      logic                   oirq;
   } ustw_state_s;

   ustw_state_s st_q;
   ustw_state_s st_d;

   // -----------------------------------------------------------------
   // pin sampling
   // -----------------------------------------------------------------
   logic [1:0] pins_s;
   logic       sda_s;
   logic       scl_s;
   logic       scl_rise;
   logic       scl_fall;
   logic       sdad_rise;
   logic       sdad_fall;

   ustw_sync #(
      .W (2)
   ) u_sync (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .d_i     ({sda_i, scl_i}),
      .q_o     (pins_s)
   );

   assign sda_s = pins_s[1];
   assign scl_s = pins_s[0];

   // clock pin edges; pin rate must stay under half the sample rate
   ustw_edge u_scl_edge (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .lvl_i   (scl_s),
      .rise_o  (scl_rise),
      .fall_o  (scl_fall)
   );

   // sda seen through a short delay so scl is valid when sda moves
   ustw_edge u_sda_edge (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .lvl_i   (st_q.sda_dly[SDA_DLY_CYC-1]),
      .rise_o  (sdad_rise),
      .fall_o  (sdad_fall)
   );

   // -----------------------------------------------------------------
   // decode and clock selection
   // -----------------------------------------------------------------
   logic wr_ctrl;
   logic wr_st;
   logic wr_data;
   logic wr_port;
   logic two;
   logic ext;
   logic sw_clk;
   logic sw_tc;
   logic cnt_tick;
   logic shf_tick;
   logic ovf;
   logic start_c;
   logic stop_c;
   logic hold;
   logic opn;
   logic dcol;

   // register strobes
   assign wr_ctrl = we_i & (addr_i == ADDR_CTRL);
   assign wr_st   = we_i & (addr_i == ADDR_STATUS);
   assign wr_data = we_i & (addr_i == ADDR_DATA);
   assign wr_port = we_i & (addr_i == ADDR_PORT);
   assign sw_clk  = wr_ctrl & wdata_i[CTRL_CLK];
   assign sw_tc   = wr_ctrl & wdata_i[CTRL_TC];
   assign two     = (st_q.wm == WM_TWO) | (st_q.wm == WM_TWO_HOLD);
   assign ext     = st_q.cs[1];

   // inputs stay live in every wire mode, including none
   always_comb begin
      if (ext & st_q.tcsel) begin
         cnt_tick = sw_tc;
      end else if (ext) begin
         cnt_tick = scl_rise | scl_fall;
      end else if (st_q.cs[0]) begin
         cnt_tick = timer_match_i;
      end else begin
         cnt_tick = sw_clk;
      end
   end

   // shift on the sample edge; in two-wire mode with cs1 high and cs0 low that is scl rise
   always_comb begin
      if (ext) begin
         shf_tick = st_q.cs[0] ? scl_fall : scl_rise;
      end else if (st_q.cs[0]) begin
         shf_tick = timer_match_i;
      end else begin
         shf_tick = sw_clk;
      end
   end

   // overflow on fifteen to zero; a counter write cancels the count
   assign ovf = cnt_tick & ~wr_st & (st_q.cnt == CNT_MAX);

   // bus conditions, detected only in two-wire mode
   assign start_c = two & sdad_fall & scl_s;
   assign stop_c  = two & sdad_rise & scl_s;

   // slave-side hold sources; master never needs them
   assign hold = st_q.shold | ((st_q.wm == WM_TWO_HOLD) & st_q.of);

   // latch always open with an internal clock; with scl as source, open while the clock pin sits in its first half-cycle
   assign opn  = ~ext | (scl_s == st_q.cs[0]);
   assign dcol = two & (st_q.shift[DW-1] != sda_s);

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      st_d = st_q;

      // control and port registers; the toggle strobe is not stored, the clock strobe only as tcsel with cs1 set
      if (wr_ctrl) begin
         st_d.sie   = wdata_i[CTRL_SIE];
         st_d.oie   = wdata_i[CTRL_OIE];
         st_d.wm    = ustw_mode_e'(wdata_i[CTRL_WM_LO +: 2]);
         st_d.cs    = wdata_i[CTRL_CS_LO +: 2];
         st_d.tcsel = wdata_i[CTRL_CLK] & wdata_i[CTRL_CS_LO + 1];
      end
      if (wr_port) begin
         st_d.dir_sda = wdata_i[PORT_DIR_SDA];
         st_d.dir_scl = wdata_i[PORT_DIR_SCL];
         st_d.prt_sda = wdata_i[PORT_OUT_SDA];
         st_d.prt_scl = wdata_i[PORT_OUT_SCL];
         st_d.dir_do  = wdata_i[PORT_DIR_DO];
      end else if (sw_tc) begin
         st_d.prt_scl = ~st_q.prt_scl; // toggle strobe flips the clock pin
      end

      // shift data: a write in the same cycle wins over the shift
      if (wr_data) begin
         st_d.shift = wdata_i;
      end else if (shf_tick) begin
         st_d.shift = {st_q.shift[DW-2:0], sda_s};
      end

      // counter: software preset (fourteen for ack) beats counting
      if (wr_st) begin
         st_d.cnt = wdata_i[CW-1:0];
      end else if (cnt_tick) begin
         st_d.cnt = st_q.cnt + CNT_ONE;
      end

      // completed byte copied for later reading
      if (ovf) begin
         st_d.buffer = st_d.shift;
      end

      // start and stop flags: hardware set wins over a write-one clear
      st_d.of = ovf | (st_q.of & ~(wr_st & wdata_i[ST_OF]));
      st_d.pf = stop_c | (st_q.pf & ~(wr_st & wdata_i[ST_PF]));
      if (two) begin
         st_d.sf = start_c | (st_q.sf & ~(wr_st & wdata_i[ST_SF]));
      end else begin
         st_d.sf = scl_rise | scl_fall | (st_q.sf & ~(wr_st & wdata_i[ST_SF]));
      end

      // start hold armed at scl fall, released once the flag is cleared
      st_d.shold = two & st_d.sf & (st_q.shold | scl_fall);

      // sda delay line for the start and stop detector
      st_d.sda_dly = {st_q.sda_dly[SDA_DLY_CYC-2:0], sda_s};

      // output latch sees a fresh msb immediately while open
      if (opn) begin
         st_d.latch = st_d.shift[DW-1];
      end

      // pins: open drain in two-wire mode, plain port otherwise
      if (two) begin
         st_d.sda_o  = 1'b0;
         st_d.sda_oe = st_d.dir_sda & (~st_d.latch | ~st_d.prt_sda);
         st_d.scl_o  = 1'b0;
         st_d.scl_oe = st_d.dir_scl & (~st_d.prt_scl | st_d.shold |
                                       ((st_d.wm == WM_TWO_HOLD) & st_d.of));
      end else begin
         st_d.sda_o  = st_d.prt_sda;
         st_d.sda_oe = st_d.dir_sda;
         st_d.scl_o  = st_d.prt_scl;
         st_d.scl_oe = st_d.dir_scl;
      end
      st_d.do_o  = (st_d.wm == WM_THREE) & st_d.latch;
      st_d.do_oe = st_d.dir_do;

      // enabled flags reach the interrupt outputs
      st_d.sirq = st_d.sf & st_d.sie;
      st_d.oirq = st_d.of & st_d.oie;

      // read data stands only in the cycle after the strobe
      st_d.rdata = RST_BYTE;
      if (re_i) begin
         case (addr_i)
            ADDR_CTRL:   st_d.rdata = {st_q.sie, st_q.oie, st_q.wm, st_q.cs, 2'b00};
            ADDR_STATUS: st_d.rdata = {st_q.sf, st_q.of, st_q.pf, dcol, st_q.cnt};
            ADDR_DATA:   st_d.rdata = st_q.shift;
            ADDR_BUF:    st_d.rdata = st_q.buffer;
            ADDR_PORT:   st_d.rdata = {3'b000, st_q.dir_do, st_q.prt_scl, st_q.prt_sda,
                                       st_q.dir_scl, st_q.dir_sda};
            default:     st_d.rdata = RST_BYTE;
         endcase
      end
   end

   // single synchronous register; the start detector is clocked here, so
   // wake from a stopped clock needs a free-running sample clock
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign rdata_o     = st_q.rdata;
   assign sda_o       = st_q.sda_o;
   assign sda_oe_o    = st_q.sda_oe;
   assign scl_o       = st_q.scl_o;
   assign scl_oe_o    = st_q.scl_oe;
   assign do_o        = st_q.do_o;
   assign do_oe_o     = st_q.do_oe;
   assign start_irq_o = st_q.sirq;
   assign ovf_irq_o   = st_q.oirq;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   AST_OVF_SET: assert property (ovf |=> st_q.of && st_q.cnt == '0)
      else $error("overflow did not set flag and wrap counter");
   AST_BUF_COPY: assert property (ovf |=> st_q.buffer == st_q.shift)
      else $error("buffer not loaded at completion");
   AST_WRITE_WINS: assert property (wr_data |=> st_q.shift == $past(wdata_i))
      else $error("shift register lost a software write");
   AST_SHIFT_IN: assert property (shf_tick && !wr_data |=>
                                  st_q.shift == {$past(st_q.shift[DW-2:0]), $past(sda_s)})
      else $error("shift did not take sda");
   AST_EXT_BOTH: assert property (ext && !st_q.tcsel && (scl_rise || scl_fall) && !wr_st && !wr_ctrl
                                  |=> st_q.cnt == $past(st_q.cnt) + CNT_ONE)
      else $error("external edge not counted");
   AST_START_FLAG: assert property (start_c |=> st_q.sf && start_irq_o == st_q.sie)
      else $error("start condition not flagged");
   AST_STOP_FLAG: assert property (stop_c |=> st_q.pf)
      else $error("stop condition not flagged");
   AST_START_HOLD: assert property (two && st_q.sf && scl_fall && st_q.dir_scl && !wr_ctrl && !wr_st
                                    && !wr_port |=> scl_oe_o && !scl_o)
      else $error("scl not held after start");
   AST_OVF_HOLD: assert property (st_q.wm == WM_TWO_HOLD && st_q.of && st_q.dir_scl && !we_i
                                  |=> scl_oe_o)
      else $error("scl not held after overflow");
   AST_MODE_OFF: assert property (st_q.wm == WM_NONE && !we_i |=>
                                  scl_oe_o == st_q.dir_scl && sda_o == st_q.prt_sda)
      else $error("port pins not plain in mode none");
   AST_OPEN_DRAIN: assert property (two && !we_i |=> !sda_o && !scl_o)
      else $error("two-wire pin driven high");
   AST_DO_DIR: assert property (!st_q.dir_do && !wr_port |=> !do_oe_o)
      else $error("data output driven without direction bit");

   COV_OVF:   cover property (ovf);
   COV_START: cover property (start_c ##[1:200] scl_fall);
   COV_STOP:  cover property (stop_c);
   COV_HOLD:  cover property (st_q.wm == WM_TWO_HOLD && st_q.of && scl_oe_o);
endmodule

// File: testbench/ustw_bus_master.sv
/*
 * behavioural two-wire bus master that drives scl and sda open drain.
 * assumes the bench resolves both lines with pull-ups and feeds them back.
 */
`timescale 1ns/1ps
module ustw_bus_master (
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      scl_low_o,
   output logic      sda_low_o
);
   // 240 ns link period keeps scl far below half the system clock
   localparam int HALF_NS = 80;

   // ----------------------------------------------------------------
   // line control
   // ----------------------------------------------------------------
   // both lines released at time zero, so the pull-ups set them high
   initial begin
      scl_low_o = 1'b0;
      sda_low_o = 1'b0;
   end

   // release scl and wait until it is really high, since the slave may stretch it
   task automatic rel_scl();
      scl_low_o = 1'b0;
      while (scl_i !== 1'b1) #(HALF_NS / 4);
      #HALF_NS;
   endtask

   // sda falls while scl is high, then the master pulls the first clock low
   task automatic start_cond();
      sda_low_o = 1'b1;
      #(2 * HALF_NS); // start hold well beyond the slave's delayed sda view
      scl_low_o = 1'b1;
      #HALF_NS;
   endtask

   // one bit with scl low on entry; b=1 leaves sda free so the slave can answer
   task automatic xfer_bit(input logic b, output logic rb);
      sda_low_o = ~b;
      #HALF_NS;
      rel_scl();
      rb = sda_i;
      scl_low_o = 1'b1;
      #HALF_NS;
   endtask

   // sda rises while scl is high
   task automatic stop_cond();
      sda_low_o = 1'b1;
      #HALF_NS;
      rel_scl();
      sda_low_o = 1'b0;
      #HALF_NS;
   endtask
endmodule

// File: testbench/tb_top.sv
/*
 * self-checking bench of the two-wire core: register rows, slave receive with
 * acknowledge and stop, and counter edges with the wire outputs disabled.
 * assumes the bus master model on the far side and pull-ups on both lines.
 */
`timescale 1ns/1ps
module tb_top;
   import ustw_pkg::*;
   typedef struct { logic [AW-1:0] addr; ustw_byte_t wdata; ustw_byte_t exp; } ustw_row_s;
   logic           clock_i, rst_i, we_i, re_i;
   logic [AW-1:0]  addr_i;
   ustw_byte_t     wdata_i, rdata_o, v;
   logic           sda_o, sda_oe_o, scl_o, scl_oe_o, start_irq_o, ovf_irq_o, do_o, do_oe_o, tmatch;
   logic           m_scl_low, m_sda_low, rb;
   wire logic      scl_line, sda_line;
   int             err_total, n_compared, cyc;
   ustw_row_s      rows[6] = '{'{ADDR_DATA, 8'h96, 8'h96}, '{ADDR_STATUS, 8'h0a, 8'h0a},
                               '{ADDR_CTRL, 8'hc0, 8'hc0}, '{ADDR_BUF, 8'h55, 8'h00},
                               '{8'h20, 8'h77, 8'h00}, '{ADDR_PORT, 8'hff, 8'h1f}};

   // ----------------------------------------------------------------
   // clock, wired-and lines and instances
   // ----------------------------------------------------------------
   always #10 clock_i = ~clock_i;
   assign scl_line = ~(m_scl_low | (scl_oe_o & ~scl_o)); // pull-up wins when nobody pulls
   assign sda_line = ~(m_sda_low | (sda_oe_o & ~sda_o));

   ustw_core ustw_core_inst (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .timer_match_i(tmatch), .sda_i(sda_line),
      .sda_o(sda_o), .sda_oe_o(sda_oe_o), .scl_i(scl_line), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
      .do_o(do_o), .do_oe_o(do_oe_o), .start_irq_o(start_irq_o), .ovf_irq_o(ovf_irq_o));
   ustw_bus_master ustw_bus_master_inst (.scl_i(scl_line), .sda_i(sda_line),
      .scl_low_o(m_scl_low), .sda_low_o(m_sda_low));

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input string what, input ustw_byte_t exp, input ustw_byte_t seen);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [AW-1:0] a, input ustw_byte_t d);
      @(posedge clock_i);
      addr_i  <= a;
      wdata_i <= d;
      we_i    <= 1'b1;
      @(posedge clock_i);
      we_i    <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [AW-1:0] a, output ustw_byte_t d);
      @(posedge clock_i);
      addr_i <= a;
      re_i   <= 1'b1;
      @(posedge clock_i);
      re_i   <= 1'b0;
      #1 d = rdata_o;
   endtask

   // sync, sda delay and edge stages take about six cycles
   task automatic settle();
      repeat (12) @(posedge clock_i);
   endtask

   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // hang guard: the whole run needs a few hundred cycles
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         close_out();
      end
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      clock_i = 1'b0; rst_i = 1'b1; addr_i = '0; wdata_i = '0; we_i = 1'b0; re_i = 1'b0;
      err_total = 0; n_compared = 0; cyc = 0;
      tmatch = 1'b0;
      repeat (5) @(posedge clock_i);
      rst_i <= 1'b0;
      settle();
      rd(ADDR_STATUS, v);
      chk("status after reset", RST_BYTE, v);
      chk("scl drive after reset", 8'h00, {7'h0, scl_oe_o});
      $display("test reset done");
      // register rows: data kept, counter loads, read-only and unmapped read zero
      foreach (rows[i]) begin
         wr(rows[i].addr, rows[i].wdata);
         rd(rows[i].addr, v);
         chk("register row", rows[i].exp, v);
      end
      $display("test register rows done");
      // slave receive in two-wire mode with overflow hold, external rising edge
      wr(ADDR_DATA, 8'hff);
      wr(ADDR_PORT, 8'h0e);
      wr(ADDR_CTRL, 8'hf8);
      // link edges kept off the system clock edge, so pin sampling is no race
      #5;
      ustw_bus_master_inst.start_cond();
      settle();
      rd(ADDR_STATUS, v);
      chk("start flag", 8'h80, v & 8'h80);
      chk("start irq", 8'h01, {7'h0, start_irq_o});
      chk("scl held after start", 8'h01, {7'h0, scl_oe_o & ~scl_line});
      wr(ADDR_STATUS, 8'h80);
      #5;
      for (int i = 7; i >= 0; i--) ustw_bus_master_inst.xfer_bit(rows[0].exp[i] ^ i[0], rb);
      settle();
      rd(ADDR_BUF, v);
      chk("buffer after byte", 8'h96 ^ 8'haa, v);
      rd(ADDR_STATUS, v);
      chk("overflow flag", 8'h40, v & 8'hcf);
      chk("scl held after byte", 8'h01, {7'h0, scl_oe_o & ~scl_line});
      chk("overflow irq", 8'h01, {7'h0, ovf_irq_o});
      // acknowledge: sda low, counter preset to fourteen, then release
      wr(ADDR_DATA, 8'h00);
      wr(ADDR_PORT, 8'h0f);
      wr(ADDR_STATUS, 8'h4e);
      #5;
      ustw_bus_master_inst.xfer_bit(1'b1, rb);
      chk("acknowledge level", 8'h00, {7'h0, rb});
      settle();
      rd(ADDR_STATUS, v);
      chk("overflow after ack", 8'h40, v & 8'h4f);
      wr(ADDR_PORT, 8'h0e);
      wr(ADDR_STATUS, 8'h40);
      chk("sda drive off", 8'h00, {7'h0, sda_oe_o});
      #5;
      ustw_bus_master_inst.stop_cond();
      settle();
      rd(ADDR_STATUS, v);
      chk("stop flag", 8'h20, v & 8'ha0);
      $display("test slave receive done");
      // wire mode none: edges still count and set the start flag, outputs off
      wr(ADDR_PORT, 8'h00);
      wr(ADDR_CTRL, 8'h08);
      wr(ADDR_STATUS, 8'hef);
      #5;
      ustw_bus_master_inst.start_cond();
      settle();
      rd(ADDR_STATUS, v);
      chk("edge at counter max", 8'hc0, v & 8'hef);
      chk("edge start flag", 8'h80, v & 8'h80);
      chk("scl drive in mode none", 8'h00, {7'h0, scl_oe_o});
      chk("masked overflow irq", 8'h00, {7'h0, ovf_irq_o});
      #5;
      ustw_bus_master_inst.stop_cond();
      settle();
      rd(ADDR_STATUS, v);
      chk("rise counted, no stop", 8'h01, v & 8'h2f);
      $display("test mode none done");
      // three-wire mode: software strobe and timer pulse clock the shift register
      wr(ADDR_PORT, 8'h10);
      wr(ADDR_DATA, 8'h80);
      wr(ADDR_CTRL, 8'h10);
      rd(ADDR_CTRL, v);
      chk("three-wire control", 8'h10, v);
      chk("data out latch", 8'h03, {6'h0, do_oe_o, do_o});
      wr(ADDR_CTRL, 8'h12);
      rd(ADDR_DATA, v);
      chk("software clock shift", 8'h01, v);
      chk("data out new msb", 8'h02, {6'h0, do_oe_o, do_o});
      wr(ADDR_CTRL, 8'h14);
      // timer pulse beside a data write, then one pulse alone
      @(posedge clock_i);
      addr_i  <= ADDR_DATA;
      wdata_i <= 8'h5a;
      we_i    <= 1'b1;
      tmatch  <= 1'b1;
      @(posedge clock_i);
      we_i    <= 1'b0;
      @(posedge clock_i);
      tmatch  <= 1'b0;
      rd(ADDR_DATA, v);
      chk("timer shift after kept write", 8'hb5, v);
      rd(ADDR_STATUS, v);
      chk("counter over strobes", 8'h04, v & 8'h0f);
      $display("test three-wire done");
      close_out();
   end
endmodule
